// ===== pkg/limit_switch_cfg.svh
// offsets, field positions, reset values and timing of the limit switch monitor
`ifndef LIMIT_SWITCH_CFG_SVH
`define LIMIT_SWITCH_CFG_SVH
`define LSM_OFS_CTRL      12'h000
`define LSM_OFS_CONFIG    12'h004
`define LSM_OFS_DECEL     12'h008
`define LSM_OFS_STATUS    12'h00c
`define LSM_CTRL_INIT     0
`define LSM_CTRL_RELEASE  1
`define LSM_CFG_MASK_LSB  0
`define LSM_CFG_POL_LSB   4
`define LSM_CFG_REF_LSB   8
`define LSM_ST_ERR        4
`define LSM_ST_POWER      5
`define LSM_ST_LOOP       6
`define LSM_ST_BRAKE      7
`define LSM_ST_REF        8
`define LSM_ST_EQUIP      9
`define LSM_ST_STATE_LSB  12
`define LSM_SW_NEG_STOP   0
`define LSM_SW_POS_STOP   1
`define LSM_SW_NEG_BRAKE  2
`define LSM_SW_POS_BRAKE  3
`define LSM_MASK_RESET    4'hf
`define LSM_POL_RESET     4'hf
`define LSM_REF_RESET     2'h0
`define LSM_DECEL_RESET   32'h0000_1000
`define LSM_STARTUP_TICKS 2'h3
`endif

// ===== pkg/limit_switch_pkg.sv
// types shared by the limit switch monitor
package limit_switch_pkg;
	typedef enum logic [2:0] {AX_UNINIT, AX_READY, AX_BRAKING, AX_FAULT, AX_INITED} axis_state_t;
endpackage

// ===== logic/switch_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module switch_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] pinIn,
	output      logic [WIDTH-1:0] pinSync
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_t;

	sync_t st;
	sync_t next_st;

	// first stage feeds only the second
	always_comb begin
		next_st.stage1 = pinIn;
		next_st.stage2 = st.stage1;
	end

	// state register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pinSync = st.stage2;
endmodule // switch_sync

// ===== logic/limit_switch_monitor.sv
// limit and reference switch supervision for one axis, with APB registers
//
// Behaviour
// - four switch inputs: two stops, two brakes
// - one selectable switch serves as reference
// - negative switches guard motion toward motor
// - negative stop in negative motion cuts power
// - negative brake switch starts programmed deceleration ramp
// - after braking, motor stays powered and controlled
// - brake overrun onto stop still cuts power
// - positive brake switch mirrors negative one
// - positive stop switch mirrors negative one
// - switch recognised only when mask bit set
// - cleared polarity bit means active low
// - set polarity means active high, default set
// - init command restores all axis parameters
// - equipment detected only during start-up
// - shut-off opens loop and disables stage
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "limit_switch_cfg.svh"
module limit_switch_monitor
	import limit_switch_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	input  wire logic        negHardStopSw,
	input  wire logic        posHardStopSw,
	input  wire logic        negBrakeSw,
	input  wire logic        posBrakeSw,
	input  wire logic        equipPresent,
	input  wire logic        moveNeg,
	input  wire logic        movePos,
	output      logic        powerStageEnable,
	output      logic        loopClosed,
	output      logic        brakeRamp,
	output      logic [31:0] decelValue,
	output      logic        axisError,
	output      logic        refSwitchHit
);
	typedef struct packed {
		axis_state_t axis;
		logic [3:0]  mask;
		logic [3:0]  polarity;
		logic [1:0]  refSel;
		logic [31:0] decel;
		logic [3:0]  active;
		logic [1:0]  startCnt;
		logic        detectDone;
		logic        equipDetected;
		logic        axisError;
		logic        powerOn;
		logic        brake;
		logic        refHit;
		logic        ready;
		logic        slvErr;
		logic [31:0] rdata;
	} mon_t;

	mon_t       st;
	mon_t       next_st;
	logic [4:0] pinSync;
	logic [3:0] level;
	logic       apbSetup;
	logic       apbWrite;
	logic       initCmd;
	logic       releaseCmd;
	logic       negStopHit;
	logic       posStopHit;
	logic       brakeHit;
	logic       unmapped;

	// pins pass two flip-flops before use
	switch_sync #(
		.WIDTH(5)
	) u_sync (
		.clock  (clock),
		.resetn (resetn),
		.pinIn  ({equipPresent, posBrakeSw, negBrakeSw, posHardStopSw, negHardStopSw}),
		.pinSync(pinSync)
	);

	// polarity first, masking afterwards
	assign level = pinSync[3:0] ~^ st.polarity;

	// bus strobes and commands
	assign apbSetup   = psel && !penable;
	assign apbWrite   = psel && penable && st.ready && pwrite;
	assign initCmd    = apbWrite && (paddr == `LSM_OFS_CTRL) && pwdata[`LSM_CTRL_INIT];
	assign releaseCmd = apbWrite && (paddr == `LSM_OFS_CTRL) && pwdata[`LSM_CTRL_RELEASE];

	// direction-qualified hits on the filtered switches
	assign negStopHit = st.active[`LSM_SW_NEG_STOP] && moveNeg;
	assign posStopHit = st.active[`LSM_SW_POS_STOP] && movePos;
	assign brakeHit   = (st.active[`LSM_SW_NEG_BRAKE] && moveNeg)
		|| (st.active[`LSM_SW_POS_BRAKE] && movePos);

	// address outside the register map
	assign unmapped = (paddr != `LSM_OFS_CTRL) && (paddr != `LSM_OFS_CONFIG)
		&& (paddr != `LSM_OFS_DECEL) && (paddr != `LSM_OFS_STATUS);

	// next state of the whole monitor
	always_comb begin
		next_st = st;
		next_st.active = level & st.mask;
		next_st.refHit = st.active[st.refSel];
		// start-up detection window, closed for good afterwards
		if (!st.detectDone) begin
			if (st.startCnt == `LSM_STARTUP_TICKS) begin
				next_st.detectDone    = 1'b1;
				next_st.equipDetected = pinSync[4];
			end else begin
				next_st.startCnt = st.startCnt + 2'h1;
			end
		end
		// axis sequencing
		case (st.axis)
			AX_UNINIT: begin
				if (initCmd && st.equipDetected) begin
					next_st.axis = AX_READY;
				end
			end
			AX_READY: begin
				if (negStopHit || posStopHit) begin
					next_st.axis      = AX_FAULT;
					next_st.axisError = 1'b1;
				end else if (brakeHit) begin
					next_st.axis = AX_BRAKING;
				end
			end
			AX_BRAKING: begin
				if (negStopHit || posStopHit) begin
					next_st.axis      = AX_FAULT;
					next_st.axisError = 1'b1;
				end else if (!moveNeg && !movePos) begin
					next_st.axis = AX_READY;
				end
			end
			AX_FAULT: begin
				if (initCmd) begin
					next_st.axis = AX_INITED;
				end
			end
			AX_INITED: begin
				if (initCmd) begin
					next_st.axis = AX_INITED;
				end else if (releaseCmd) begin
					next_st.axis      = AX_READY;
					next_st.axisError = 1'b0;
				end
			end
			default: begin
				next_st.axis = AX_UNINIT;
			end
		endcase
		// init from braking keeps the axis running
		if (initCmd && (st.axis == AX_BRAKING) && !negStopHit && !posStopHit) begin
			next_st.axis = AX_READY;
		end
		next_st.powerOn = (next_st.axis == AX_READY) || (next_st.axis == AX_BRAKING);
		next_st.brake   = (next_st.axis == AX_BRAKING);
		// register writes
		if (apbWrite && (paddr == `LSM_OFS_CONFIG)) begin
			next_st.mask     = pwdata[`LSM_CFG_MASK_LSB +: 4];
			next_st.polarity = pwdata[`LSM_CFG_POL_LSB +: 4];
			next_st.refSel   = pwdata[`LSM_CFG_REF_LSB +: 2];
		end else if (apbWrite && (paddr == `LSM_OFS_DECEL)) begin
			next_st.decel = pwdata;
		end
		// init overwrites whatever was changed
		if (initCmd) begin
			next_st.mask     = `LSM_MASK_RESET;
			next_st.polarity = `LSM_POL_RESET;
			next_st.refSel   = `LSM_REF_RESET;
			next_st.decel    = `LSM_DECEL_RESET;
		end
		// zero-wait slave: pready follows the setup cycle
		next_st.ready  = apbSetup;
		next_st.slvErr = 1'b0;
		next_st.rdata  = 32'h0000_0000;
		if (apbSetup) begin
			if (paddr == `LSM_OFS_CTRL) begin
				next_st.rdata = 32'h0000_0000;
			end else if (paddr == `LSM_OFS_CONFIG) begin
				next_st.rdata[`LSM_CFG_MASK_LSB +: 4] = st.mask;
				next_st.rdata[`LSM_CFG_POL_LSB +: 4]  = st.polarity;
				next_st.rdata[`LSM_CFG_REF_LSB +: 2]  = st.refSel;
			end else if (paddr == `LSM_OFS_DECEL) begin
				next_st.rdata = st.decel;
			end else if (paddr == `LSM_OFS_STATUS) begin
				next_st.rdata[3:0]                     = st.active;
				next_st.rdata[`LSM_ST_ERR]             = st.axisError;
				next_st.rdata[`LSM_ST_POWER]           = st.powerOn;
				next_st.rdata[`LSM_ST_LOOP]            = st.powerOn;
				next_st.rdata[`LSM_ST_BRAKE]           = st.brake;
				next_st.rdata[`LSM_ST_REF]             = st.refHit;
				next_st.rdata[`LSM_ST_EQUIP]           = st.equipDetected;
				next_st.rdata[`LSM_ST_STATE_LSB +: 3]  = st.axis;
			end else begin
				next_st.slvErr = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st          <= '0;
			st.axis     <= AX_UNINIT;
			st.mask     <= `LSM_MASK_RESET;
			st.polarity <= `LSM_POL_RESET;
			st.refSel   <= `LSM_REF_RESET;
			st.decel    <= `LSM_DECEL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flops
	assign prdata           = st.rdata;
	assign pready           = st.ready;
	assign pslverr          = st.slvErr;
	assign powerStageEnable = st.powerOn;
	assign loopClosed       = st.powerOn;
	assign brakeRamp        = st.brake;
	assign decelValue       = st.decel;
	assign axisError        = st.axisError;
	assign refSwitchHit     = st.refHit;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	neg_stop_cut_a: assert property (negStopHit && st.axis == AX_READY
		|=> !powerStageEnable && axisError) else $error("neg stop did not cut power");
	pos_stop_cut_a: assert property (posStopHit && st.axis == AX_READY
		|=> !powerStageEnable && axisError) else $error("pos stop did not cut power");
	brake_start_a: assert property (st.axis == AX_READY && brakeHit && !negStopHit
		&& !posStopHit |=> brakeRamp && powerStageEnable) else $error("brake not started");
	brake_hold_a: assert property (brakeRamp && !moveNeg && !movePos && !negStopHit
		&& !posStopHit |=> powerStageEnable && loopClosed) else $error("power lost after braking");
	overrun_stop_a: assert property (brakeRamp && (negStopHit || posStopHit)
		|=> !powerStageEnable) else $error("overrun did not cut power");
	shut_pair_a: assert property (powerStageEnable == loopClosed)
		else $error("loop and stage disagree");
	mask_gate_a: assert property (##1 (st.active & ~$past(st.mask)) == 4'h0)
		else $error("masked switch seen");
	pol_low_a: assert property (!st.polarity[2] && st.mask[2] && !pinSync[2]
		|=> st.active[2]) else $error("active-low switch missed");
	pol_idle_a: assert property (!st.polarity[2] && pinSync[2]
		|=> !st.active[2]) else $error("resting active-low switch seen");
	pol_high_a: assert property (st.polarity[0] && st.mask[0] && pinSync[0]
		|=> st.active[0]) else $error("active-high switch missed");
	init_restore_a: assert property (initCmd |=> st.mask == `LSM_MASK_RESET
		&& decelValue == `LSM_DECEL_RESET) else $error("init did not restore");
	error_hold_a: assert property (axisError && !releaseCmd |=> axisError)
		else $error("axis error dropped early");
	detect_once_a: assert property (st.detectDone |=> $stable(st.equipDetected))
		else $error("equipment changed after start-up");
	ref_follow_a: assert property (##1 refSwitchHit == $past(st.active[st.refSel]))
		else $error("reference hit wrong");

	hard_stop_c: cover property (st.axis == AX_READY ##1 st.axis == AX_FAULT);
	brake_done_c: cover property (brakeRamp ##[1:20] st.axis == AX_READY);
	recovery_c: cover property (st.axis == AX_INITED ##1 st.axis == AX_READY);
	brake_overrun_c: cover property (brakeRamp ##1 st.axis == AX_FAULT);
	masked_switch_c: cover property (!st.mask[3] && level[3] ##1 !st.active[3]);

	// zero-wait bus answer
	ready_pulse_a: assert property (apbSetup
		|=> pready)
		else $error("no ready after setup");
	ready_single_a: assert property (pready
		|=> !pready)
		else $error("ready held too long");
	unmapped_err_a: assert property (apbSetup && unmapped
		|=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (apbSetup && !unmapped
		|=> !pslverr)
		else $error("error on a mapped register");
	err_ready_a: assert property (pslverr
		|-> pready)
		else $error("error without ready");
	idle_rdata_a: assert property (!pready
		|-> prdata == 32'h0000_0000)
		else $error("read data outside access");

	// register contents
	decel_write_a: assert property (apbWrite && paddr == `LSM_OFS_DECEL
		|=> decelValue == $past(pwdata))
		else $error("deceleration write lost");
	decel_read_a: assert property (apbSetup && !pwrite && paddr == `LSM_OFS_DECEL
		|=> prdata == $past(decelValue))
		else $error("deceleration read wrong");
	config_write_a: assert property (apbWrite && paddr == `LSM_OFS_CONFIG
		|=> st.mask == $past(pwdata[`LSM_CFG_MASK_LSB +: 4]) && st.polarity == $past(pwdata[`LSM_CFG_POL_LSB +: 4]))
		else $error("configuration write lost");
	status_ro_a: assert property (apbWrite && paddr == `LSM_OFS_STATUS
		|=> $stable(st.mask) && $stable(st.polarity) && $stable(decelValue))
		else $error("status write changed settings");

	// axis sequencing
	still_run_a: assert property (st.axis == AX_READY && !moveNeg && !movePos
		|=> powerStageEnable && !brakeRamp)
		else $error("idle axis lost power");
	wrong_dir_a: assert property (st.axis == AX_READY && st.active[`LSM_SW_NEG_STOP] && !moveNeg
		&& !posStopHit |=> !axisError && powerStageEnable)
		else $error("stop acted against direction");
	brake_run_a: assert property (brakeRamp && !negStopHit && !posStopHit
		|=> powerStageEnable && loopClosed)
		else $error("power lost while braking");
	fault_off_a: assert property (st.axis == AX_FAULT
		|=> !powerStageEnable && !loopClosed && axisError)
		else $error("faulted axis powered");
	hold_fault_a: assert property (st.axis == AX_FAULT && !initCmd
		|=> st.axis == AX_FAULT)
		else $error("fault left without init");
	fault_init_a: assert property (st.axis == AX_FAULT && initCmd
		|=> st.axis == AX_INITED && axisError)
		else $error("init did not arm release");
	release_run_a: assert property (st.axis == AX_INITED && releaseCmd && !initCmd
		|=> st.axis == AX_READY && powerStageEnable && !axisError)
		else $error("release did not restart axis");
	uninit_gate_a: assert property (st.axis == AX_UNINIT && !st.equipDetected
		|=> st.axis == AX_UNINIT && !powerStageEnable)
		else $error("axis started without equipment");
	detect_late_a: assert property (!st.detectDone
		|-> !st.equipDetected)
		else $error("equipment seen before sampling");
	loop_state_a: assert property (powerStageEnable
		|-> (st.axis == AX_READY || st.axis == AX_BRAKING))
		else $error("power on in a stopped state");
	stop_still_a: assert property (!moveNeg && !movePos && !axisError
		|=> !axisError)
		else $error("stop tripped while standing");
endmodule // limit_switch_monitor

// ===== tb/switch_far_model.sv
// mechanical switches and positioning unit as seen from the monitor pins
`timescale 1ns/100ps
module switch_far_model (
	input  wire logic [3:0] swActive,
	input  wire logic [3:0] swPolarity,
	input  wire logic       unitAttached,
	output      logic       negHardStopSw,
	output      logic       posHardStopSw,
	output      logic       negBrakeSw,
	output      logic       posBrakeSw,
	output      logic       equipPresent
);
	// actuated switch shows its active level, resting switch the other one
	assign {posBrakeSw, negBrakeSw, posHardStopSw, negHardStopSw} =
		~(swActive ^ swPolarity);
	// unit plugged or not, held steady by the mechanics
	assign equipPresent = unitAttached;
endmodule // switch_far_model

// ===== tb/limit_switch_monitor_tb_top.sv
// self-checking bench for the limit switch monitor
`timescale 1ns/100ps
`include "limit_switch_cfg.svh"
module limit_switch_monitor_tb_top;
	logic        clock, resetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, decelValue, rdata;
	logic        negHardStopSw, posHardStopSw, negBrakeSw, posBrakeSw, equipPresent;
	logic        moveNeg, movePos, powerStageEnable, loopClosed, brakeRamp, axisError;
	logic        refSwitchHit, attach;
	logic [3:0]  act, polM;
	int          fails, check_count;

	// design and far side
	limit_switch_monitor u_limit_switch_monitor (.clock(clock), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .negHardStopSw(negHardStopSw),
		.posHardStopSw(posHardStopSw), .negBrakeSw(negBrakeSw), .posBrakeSw(posBrakeSw),
		.equipPresent(equipPresent), .moveNeg(moveNeg), .movePos(movePos),
		.powerStageEnable(powerStageEnable), .loopClosed(loopClosed), .brakeRamp(brakeRamp),
		.decelValue(decelValue), .axisError(axisError), .refSwitchHit(refSwitchHit));
	switch_far_model u_switch_far_model (.swActive(act), .swPolarity(polM), .unitAttached(attach),
		.negHardStopSw(negHardStopSw), .posHardStopSw(posHardStopSw), .negBrakeSw(negBrakeSw),
		.posBrakeSw(posBrakeSw), .equipPresent(equipPresent));

	// 40 MHz clock
	always #12.5 clock = ~clock;

	// verdict and end of run
	task automatic results;
		if (fails == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer: setup, then access held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			results();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// register write and masked register read
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata & m, e);
	endtask

	// let switches pass the synchroniser, then compare {error, power, loop, brake}
	task automatic pins(input logic [3:0] e);
		repeat (6) @(posedge clock);
		chk({28'h0, axisError, powerStageEnable, loopClosed, brakeRamp}, {28'h0, e});
	endtask

	// reset held 20 cycles, then start-up sampling time
	task automatic doReset;
		resetn <= 1'b0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		repeat (8) @(posedge clock);
	endtask

	// main sequence
	initial begin
		{clock, resetn, psel, penable, pwrite, moveNeg, movePos, attach} = '0;
		{paddr, pwdata, fails, check_count} = '0;
		act = 4'h0;
		polM = 4'hf;
		doReset();
		attach <= 1'b1;
		repeat (4) @(posedge clock);
		rdm(`LSM_OFS_STATUS, 32'h200, 32'h0);
		wr(`LSM_OFS_CTRL, 32'h1);
		rdm(`LSM_OFS_STATUS, 32'h7000, 32'h0);
		doReset();
		wr(`LSM_OFS_STATUS, 32'hffff_ffff);
		chk({31'h0, rerr}, 32'h0);
		rdm(`LSM_OFS_CONFIG, 32'hffffffff, 32'h0ff);
		rdm(`LSM_OFS_DECEL, 32'hffffffff, 32'h1000);
		rdm(12'h010, 32'hffffffff, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		rdm(`LSM_OFS_STATUS, 32'h200, 32'h200);
		wr(`LSM_OFS_CTRL, 32'h1);
		rdm(`LSM_OFS_STATUS, 32'h7000, 32'h1000);
		wr(`LSM_OFS_CTRL, 32'h2);
		rdm(`LSM_OFS_STATUS, 32'h7000, 32'h1000);
		pins(4'b0110);
		wr(`LSM_OFS_DECEL, 32'h0000_2345);
		@(posedge clock);
		chk(decelValue, 32'h0000_2345);
		wr(`LSM_OFS_CONFIG, 32'h2bf);
		polM <= 4'hb;
		moveNeg <= 1'b1;
		act <= 4'h4;
		pins(4'b0111);
		chk({31'h0, refSwitchHit}, 32'h1);
		rdm(`LSM_OFS_STATUS, 32'h73ff, 32'h23e4);
		act <= 4'h5;
		pins(4'b1000);
		moveNeg <= 1'b0;
		act <= 4'h0;
		wr(`LSM_OFS_CTRL, 32'h2);
		rdm(`LSM_OFS_STATUS, 32'h7000, 32'h3000);
		polM <= 4'hf;
		wr(`LSM_OFS_CTRL, 32'h1);
		rdm(`LSM_OFS_CONFIG, 32'hffffffff, 32'h0ff);
		chk(decelValue, 32'h1000);
		wr(`LSM_OFS_CTRL, 32'h2);
		pins(4'b0110);
		wr(`LSM_OFS_CONFIG, 32'h0f7);
		movePos <= 1'b1;
		act <= 4'h8;
		pins(4'b0110);
		act <= 4'h9;
		pins(4'b0110);
		act <= 4'hb;
		pins(4'b1000);
		movePos <= 1'b0;
		act <= 4'h0;
		wr(`LSM_OFS_CTRL, 32'h3);
		rdm(`LSM_OFS_STATUS, 32'h7000, 32'h4000);
		wr(`LSM_OFS_CTRL, 32'h2);
		movePos <= 1'b1;
		act <= 4'h8;
		pins(4'b0111);
		movePos <= 1'b0;
		pins(4'b0110);
		results();
	end
endmodule // limit_switch_monitor_tb_top
